//--- rtl/adsph_port.sv
// Purpose: Serial data port of a sigma-delta converter, device side.
// Assumes: Host drives select, serial clock and serial input; core clock
//   is the internal oscillator; serial clock idles high.
// Notes: The combined data/ready line is a selected view of link flops and the core ready flop.
//
// Contract
// - The falling serial clock edge is active; output bits change after it.
// - Select low makes the device drive the data/ready line.
// - Select high releases the data/ready line to high impedance.
// - After the rising edge that ends a read the line is driven high.
// - Ready returns high once the result has been read out.
// - In conversion modes a result may be read again while ready is high.
// - In continuous read mode each word can be read once only.
`timescale 1ns/1ns
`default_nettype none
module adsph_port
  import adsph_pkg::*;
(
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic sdo,
  output logic sdo_oe,
  // Conversion results from the modulator
  input wire adsph_pkg::adsph_word_t conv_word,
  input wire logic conv_valid,
  output logic conv_ready,
  // Mode: high selects continuous read, low single or continuous conversion
  input wire logic cont_read,
  // Words shifted in by the host
  output adsph_pkg::adsph_word_t rx_word,
  output logic rx_valid
);

  import adsph_pkg::*;

  typedef struct packed {
    logic oe;
    logic tgl_q;
    adsph_word_t hold;
    logic word_ok;
    logic rdy_n;
    adsph_word_t rx;
    logic rx_valid;
  } adsph_ref_t;

  typedef struct packed {
    logic run;
    logic ok;
    logic [CNT_W-1:0] cnt;
    logic bit_out;
  } adsph_neg_t;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [WORD_W-1:0] shreg;
    logic done;
  } adsph_pos_t;

  typedef struct packed {
    logic tgl;
    adsph_word_t rx;
  } adsph_hand_t;

  function automatic logic pick(input adsph_word_t w, input logic ok,
                                input logic [CNT_W-1:0] idx);
    logic [CNT_W-1:0] pos;
    pos = CNT_LAST - idx;
    pick = ok ? w.data[pos] : 1'b1;
  endfunction : pick

  adsph_ref_t r;
  adsph_ref_t next_r;
  adsph_neg_t n;
  adsph_neg_t next_n;
  adsph_pos_t p;
  adsph_pos_t next_p;
  adsph_hand_t h;
  adsph_hand_t next_h;

  logic lk_rst_n;
  logic cs_s;
  logic tgl_s;
  logic done_ev;
  logic load;
  logic fin_edge;
  adsph_word_t buf_word;
  logic buf_valid;

  // The link counters and shifter live only inside a frame; select high holds them reset.
  assign lk_rst_n = reset_n & ~cs_n;

  adsph_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) u_cs_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .din(cs_n),
    .dout(cs_s)
  );

  adsph_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_done_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .din(h.tgl),
    .dout(tgl_s)
  );

  adsph_buf #(
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(ref_clk),
    .reset_n(reset_n),
    .in_word(conv_word),
    .in_valid(conv_valid),
    .in_ready(conv_ready),
    .out_word(buf_word),
    .out_valid(buf_valid),
    .out_ready(load)
  );

  // Core side: line enable, word holding and ready tracking.
  assign done_ev = (tgl_s != r.tgl_q);
  // Words are only swapped while deselected, so a frame sees a steady word.
  // In continuous read the held word waits for its one read; this stalls
  // the buffer and, once full, the modulator.
  assign load = buf_valid && cs_s && !done_ev &&
                (!cont_read || !r.word_ok);

  always_comb begin
    next_r = r;
    next_r.oe = ~cs_s;
    next_r.tgl_q = tgl_s;
    next_r.rx_valid = 1'b0;
    if (done_ev) begin
      next_r.rdy_n = 1'b1;
      next_r.rx = h.rx;
      next_r.rx_valid = 1'b1;
      if (cont_read) begin
        next_r.word_ok = 1'b0;
      end
    end else if (load) begin
      next_r.hold = buf_word;
      next_r.word_ok = 1'b1;
      next_r.rdy_n = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.rdy_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Link side, active edge: present the next bit.
  always_comb begin
    next_n = n;
    if (!n.run) begin
      next_n.run = 1'b1;
      next_n.ok = r.word_ok;
      next_n.cnt = CNT_ONE;
      next_n.bit_out = pick(r.hold, r.word_ok, CNT_ZERO);
    end else if (n.cnt != CNT_FULL) begin
      next_n.cnt = n.cnt + CNT_ONE;
      next_n.bit_out = pick(r.hold, n.ok, n.cnt);
    end else begin
      next_n.bit_out = 1'b1;
    end
  end

  always_ff @(negedge sclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      n <= '0;
    end else begin
      n <= next_n;
    end
  end

  // Link side, inactive edge: sample the input and close the read.
  assign fin_edge = !p.done && (p.cnt == CNT_LAST);

  always_comb begin
    next_p = p;
    next_h = h;
    if (!p.done) begin
      next_p.shreg = {p.shreg[WORD_W-2:0], din};
      next_p.cnt = p.cnt + CNT_ONE;
    end
    if (fin_edge) begin
      next_p.done = 1'b1;
      next_h.tgl = ~h.tgl;
      next_h.rx.data = {p.shreg[WORD_W-2:0], din};
    end
  end

  always_ff @(posedge sclk or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      p <= '0;
    end else begin
      p <= next_p;
    end
  end

  // The toggle must survive deselect, so it only clears on core reset.
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      h <= '0;
    end else begin
      h <= next_h;
    end
  end

  // Before the first active edge the line shows ready (low when a word
  // waits); after the last bit it stays high until deselect.
  assign sdo = p.done ? 1'b1 : (n.run ? n.bit_out : r.rdy_n);
  assign sdo_oe = r.oe;
  assign rx_word = r.rx;
  assign rx_valid = r.rx_valid;

  property p_drive_on;
    @(posedge ref_clk) disable iff (!reset_n)
      (!cs_n) [*4] |-> sdo_oe;
  endproperty
  a_drive_on: assert property (p_drive_on)
    else $error("line not driven after select went low");

  property p_release;
    @(posedge ref_clk) disable iff (!reset_n)
      cs_n [*4] |-> !sdo_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("line not released after select went high");

  property p_release_min;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(cs_n) && sdo_oe |=> sdo_oe;
  endproperty
  a_release_min: assert property (p_release_min)
    else $error("line released too early after deselect");

  // Windows in core cycles for the line to turn on and to let go.
  localparam int DRIVE_MAX = ACTIVE_MAX_CYC;
  localparam int FREE_MIN = RELINQ_MIN_CYC;
  localparam int FREE_MAX = RELINQ_MAX_CYC;

  property p_drive_time;
    @(posedge ref_clk) disable iff (!reset_n)
      $fell(cs_n) |-> ##[1:DRIVE_MAX] sdo_oe;
  endproperty
  a_drive_time: assert property (p_drive_time)
    else $error("line not driven in time after select");

  property p_free_time;
    @(posedge ref_clk) disable iff (!reset_n)
      $rose(cs_n) |-> ##[FREE_MIN:FREE_MAX] !sdo_oe;
  endproperty
  a_free_time: assert property (p_free_time)
    else $error("line not released in time after deselect");

  // Sampled on the core clock, so the tail is seen before deselect ends it.
  property p_tail_high;
    @(posedge ref_clk) disable iff (!lk_rst_n)
      p.done |-> sdo && (n.cnt == CNT_FULL);
  endproperty
  a_tail_high: assert property (p_tail_high)
    else $error("line not high after the last bit");

  property p_bit_value;
    @(posedge sclk) disable iff (!lk_rst_n)
      n.run && !p.done && (n.cnt != CNT_ZERO) |->
        sdo == (n.ok ? r.hold.data[CNT_FULL - n.cnt] : 1'h1);
  endproperty
  a_bit_value: assert property (p_bit_value)
    else $error("output bit does not match the held word");

  property p_ready_high;
    @(posedge ref_clk) disable iff (!reset_n)
      done_ev |=> r.rdy_n ##1 (r.rdy_n || $past(load));
  endproperty
  a_ready_high: assert property (p_ready_high)
    else $error("ready not returned high after a read");

  property p_reread;
    @(posedge ref_clk) disable iff (!reset_n)
      done_ev && !cont_read && r.word_ok |=>
        r.word_ok && (r.hold == $past(r.hold));
  endproperty
  a_reread: assert property (p_reread)
    else $error("word lost after a read in conversion mode");

  property p_read_once;
    @(posedge ref_clk) disable iff (!reset_n)
      done_ev && cont_read |=> !r.word_ok;
  endproperty
  a_read_once: assert property (p_read_once)
    else $error("word still readable after a continuous read");

  property p_load_ready;
    @(posedge ref_clk) disable iff (!reset_n)
      load |=> !r.rdy_n && r.word_ok && (r.hold == $past(buf_word));
  endproperty
  a_load_ready: assert property (p_load_ready)
    else $error("new word did not raise ready");

endmodule : adsph_port
`default_nettype wire

//--- rtl/adsph_pkg.sv
// Purpose: Shared constants and types for the converter serial port.
// Assumes: Core clock of 125 MHz; serial clock supplied by the host.
// Notes: Time figures are in ns; cycle counts are derived from them.
package adsph_pkg;

  localparam int WORD_W = 24;
  localparam int CNT_W = $clog2(WORD_W + 1);
  localparam int BUF_DEPTH = 2;
  localparam int SYNC_STAGES = 2;

  localparam int REF_PERIOD_NS = 8;
  localparam int T_ACTIVE_MAX_NS = 60;
  localparam int T_RELINQ_MIN_NS = 10;
  localparam int T_RELINQ_MAX_NS = 80;
  // Longest times round down but never below one cycle; least times round up.
  localparam int ACTIVE_MAX_CYC = (T_ACTIVE_MAX_NS / REF_PERIOD_NS < 1) ?
                                  1 : T_ACTIVE_MAX_NS / REF_PERIOD_NS;
  localparam int RELINQ_MIN_CYC =
      (T_RELINQ_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int RELINQ_MAX_CYC = (T_RELINQ_MAX_NS / REF_PERIOD_NS < 1) ?
                                  1 : T_RELINQ_MAX_NS / REF_PERIOD_NS;

  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WORD_W - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(WORD_W);

  typedef struct packed {
    logic [WORD_W-1:0] data;
  } adsph_word_t;

endpackage : adsph_pkg

//--- rtl/adsph_sync.sv
// Purpose: Two flip-flop synchroniser for levels entering the core clock.
// Assumes: Each bit is an independent level or a toggle.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
`default_nettype none
module adsph_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } adsph_sync_t;

  adsph_sync_t s;
  adsph_sync_t next_s;

  always_comb begin
    next_s.meta = din;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= {RESET_VAL, RESET_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stable;

endmodule : adsph_sync
`default_nettype wire

//--- rtl/adsph_buf.sv
// Purpose: Small valid/ready buffer for conversion words.
// Assumes: Depth is a power of two.
// Notes: Full and empty come from the occupancy count.
`timescale 1ns/1ns
`default_nettype none
module adsph_buf
  import adsph_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Filling side
  input wire adsph_pkg::adsph_word_t in_word,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output adsph_pkg::adsph_word_t out_word,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

  typedef struct packed {
    adsph_word_t [DEPTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
    logic rdy;
  } adsph_buf_t;

  adsph_buf_t b;
  adsph_buf_t next_b;
  logic push;
  logic pop;

  always_comb begin
    next_b = b;
    push = in_valid && (b.cnt != FULL_CNT);
    pop = out_ready && (b.cnt != '0);
    if (push) begin
      next_b.mem[b.wr] = in_word;
      next_b.wr = b.wr + PW'(1);
    end
    if (pop) begin
      next_b.rd = b.rd + PW'(1);
    end
    next_b.cnt = b.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
    // Ready is kept in a flop so the filling side sees a registered level.
    next_b.rdy = (next_b.cnt != FULL_CNT);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      b <= '0;
      b.rdy <= 1'h1;
    end else begin
      b <= next_b;
    end
  end

  assign in_ready = b.rdy;
  assign out_valid = (b.cnt != '0);
  assign out_word = b.mem[b.rd];

endmodule : adsph_buf
`default_nettype wire

//--- verification/adsph_host.sv
// Purpose: Host controller model for the converter serial link.
// Assumes: Link clock period of 30 ns, made only while a frame runs.
// Notes: The clock stands still high between frames.
`timescale 1ns/1ns
`default_nettype none
module adsph_host (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic sdo_line
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // One 24-bit frame; bits leave and arrive most significant first.
  task automatic frame(input logic [23:0] tx, output logic [23:0] rx,
                       output logic rdy, output logic tail);
    cs_n = 1'b0;
    #40;
    rdy = sdo_line;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #15;
      rx[i] = sdo_line;
      sclk = 1'b1;
      #15;
    end
    tail = sdo_line;
    // A stale value on the input would hide a missed sample.
    din = ~din;
    #30;
    cs_n = 1'b1;
  endtask : frame
endmodule : adsph_host
`default_nettype wire

//--- verification/test_adc_serial_port_handshake.sv
// Purpose: Self-checking bench for the converter serial port.
// Assumes: Host model drives the link; bench drives the modulator side.
// Notes: Written words are the inverse of the read words.
`timescale 1ns/1ns
`default_nettype none
module test_adc_serial_port_handshake;
  import adsph_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic conv_valid = 1'b0;
  logic cont_read = 1'b1;
  adsph_word_t conv_word = '0;
  logic sclk, cs_n, din, sdo, sdo_oe, conv_ready, rx_valid;
  adsph_word_t rx_word, got_rx;
  wire logic sdo_line;
  int error_cnt = 0;
  int comparisons = 0;
  int rx_cnt = 0;

  always #4 ref_clk = ~ref_clk;
  // A released line shows the inverse so a read of it cannot pass.
  assign sdo_line = (sdo_oe === 1'b1) ? sdo : ~sdo;

  adsph_port u_adsph_port (
    .ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .din(din), .sdo(sdo), .sdo_oe(sdo_oe), .conv_word(conv_word),
    .conv_valid(conv_valid), .conv_ready(conv_ready),
    .cont_read(cont_read), .rx_word(rx_word), .rx_valid(rx_valid)
  );
  adsph_host u_adsph_host (
    .sclk(sclk), .cs_n(cs_n), .din(din), .sdo_line(sdo_line)
  );

  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      got_rx <= rx_word;
      rx_cnt <= rx_cnt + 1;
    end
  end

  task automatic fail(input string msg);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic push(input logic [23:0] w);
    int n;
    n = 0;
    @(posedge ref_clk);
    conv_word <= '{data: w};
    conv_valid <= 1'h1;
    @(negedge ref_clk);
    while (conv_ready !== 1'h1 && n < 200) begin
      n++;
      @(negedge ref_clk);
    end
    comparisons++;
    if (n >= 200) fail("word never taken");
    @(posedge ref_clk);
    conv_valid <= 1'h0;
  endtask : push

  task automatic read(input logic [23:0] exp, input logic exp_rdy);
    logic [23:0] rx;
    logic rdy;
    logic tail;
    int n0;
    n0 = rx_cnt;
    fork
      u_adsph_host.frame(~exp, rx, rdy, tail);
      begin
        #30;
        comparisons++;
        if (sdo_oe !== 1'h1) fail("line not driven");
      end
    join
    repeat (5) @(posedge ref_clk);
    comparisons += 6;
    if (sdo_oe !== 1'h0) fail("line not released");
    if (rdy !== exp_rdy) fail("ready level before frame");
    if (rx !== exp) fail("read word");
    if (tail !== 1'h1) fail("line not high after last bit");
    if (rx_cnt != n0 + 1) fail("no written word");
    if (got_rx.data !== ~exp) fail("written word");
    repeat (8) @(posedge ref_clk);
  endtask : read

  task automatic t_reset;
    @(negedge ref_clk);
    comparisons += 3;
    if (sdo_oe !== 1'h0) fail("line driven after reset");
    if (conv_ready !== 1'h1) fail("buffer not ready after reset");
    if (rx_valid !== 1'h0) fail("stray word after reset");
  endtask : t_reset

  // Receiver stalls while the buffer fills; each word leaves once.
  task automatic t_cont_read;
    push(24'ha5c3e1);
    repeat (10) @(posedge ref_clk);
    push(24'h123456);
    push(24'h800001);
    repeat (6) @(negedge ref_clk);
    comparisons++;
    if (conv_ready !== 1'h0) fail("full buffer still accepts");
    read(24'ha5c3e1, 1'h0);
    read(24'h123456, 1'h0);
    read(24'h800001, 1'h0);
    read(24'hffffff, 1'h1);
  endtask : t_cont_read

  task automatic t_conv_mode;
    @(posedge ref_clk);
    cont_read <= 1'h0;
    push(24'h3c0ff0);
    repeat (10) @(posedge ref_clk);
    read(24'h3c0ff0, 1'h0);
    read(24'h3c0ff0, 1'h1);
  endtask : t_conv_mode

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (6) @(posedge ref_clk);
    t_reset();
    t_cont_read();
    t_conv_mode();
    wrap_up();
  end

  // Six frames of under 1 us each are expected; 100 us leaves ample margin.
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule : test_adc_serial_port_handshake
`default_nettype wire
